/* File: pscs_pci_agent.sv */
// Far-side model: hold arbiter and a target answering the block's cycles.
// Assumes resolved hold line and the block's ready and data enables.
`timescale 1ns/1ns

module pscs_pci_agent (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        holdLineN,
  input  wire logic        irdyOe,
  input  wire logic        irdyOutN,
  input  wire logic        adOe,
  input  wire logic [3:0]  grantDelay,
  input  wire logic [3:0]  trdyDelay,
  input  wire logic [31:0] readWord,
  output logic             bus_hold_grant_n,
  output logic             agTrdyN,
  output logic             agTrdyOe,
  output logic [31:0]      agAd,
  output logic             agAdOe
);
  logic [3:0] gCnt;
  logic [3:0] tCnt;
  // Arbiter: grant after a delay, kept until the request drops
  always_ff @(posedge clk) begin
    if (!rst_n || holdLineN) begin
      gCnt <= 4'h0;
      bus_hold_grant_n <= 1'b1;
    end else if (gCnt >= grantDelay) bus_hold_grant_n <= 1'b0;
    else gCnt <= gCnt + 4'h1;
  end
  // Target: ready after a delay, read data while the block floats AD
  always_ff @(posedge clk) begin
    if (!rst_n || !irdyOe || (!agTrdyN && !irdyOutN)) begin
      tCnt <= 4'h0;
      agTrdyN <= 1'b1;
      agAdOe <= 1'b0;
    end else begin
      tCnt <= tCnt + 4'h1;
      agTrdyN <= !(tCnt >= trdyDelay);
      agAdOe <= !adOe;
      agAd <= readWord;
    end
  end
  assign agTrdyOe = irdyOe;
endmodule : pscs_pci_agent

/* File: pscs_pci_ctl.sv */
// PCI-side control logic of the bridge: config claim, ready handshake,
// parity, bus reset generation, hold/grant with passive release, SERR.
// Assumes clk is the PCI bus clock and all pin inputs are synchronous.
//
// How it works
// - IDSEL sampled on the address phase acts as config chip select.
// - Config read/write with IDSEL claims via DEVSEL one cycle later.
// - A data phase ends on an edge with IRDY and TRDY both low.
// - As initiator, IRDY goes low only with write data or read readiness.
// - IRDY is input as target, output as initiator, floated otherwise.
// - PAR is even parity over 32 AD bits and 4 C/BE bits.
// - PAR follows AD drive and float, one clock later.
// - PAR on own address phases, own write data, target read data.
// - Bus reset asserted at power-up and on a hard reset request.
// - Bus reset released at least 1 ms after power good rises.
// - A requested bus reset lasts at least 1 ms.
// - Bus reset output is registered on clk, the PCI bus clock.
// - Bus reset low in device reset, high after the reset count and in suspend.
// - Hold request low asks for the bus; low grant means owned.
// - Passive release pulses the hold request high for one clock.
// - Hold request floats in reset, driven high after it and in suspend.
// - A sampled SERR pulse raises an NMI when enabled.
// - C/BE carry the command on address phase, byte enables on data.
`timescale 1ns/1ns

module pscs_pci_ctl #(
  parameter int unsigned RESET_CYCLES = pscs_pkg::PSCS_RST_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  power_good_in,
  input  wire logic                  posState,
  input  wire logic                  reset_control_register,
  input  wire logic                  serrNmiEnable,
  input  wire logic                  passiveRelease,
  input  wire pscs_pkg::pscs_mst_req_s mstReq,
  input  wire logic [31:0]           cfgRdData,
  input  wire logic                  idsel,
  input  wire logic                  frameInN,
  input  wire logic                  irdyInN,
  input  wire logic                  trdyInN,
  input  wire logic                  serrInN,
  input  wire logic [31:0]           adIn,
  input  wire logic [3:0]            cbeInN,
  input  wire logic                  bus_hold_grant_n,
  output logic                       pci_bus_reset_out_n,
  output logic                       bus_hold_request_n,
  output logic                       bus_hold_request_oe,
  output logic                       frameOutN,
  output logic                       frameOe,
  output logic                       irdyOutN,
  output logic                       irdyOe,
  output logic                       devselOutN,
  output logic                       devselOe,
  output logic                       trdyOutN,
  output logic                       trdyOe,
  output logic [31:0]                adOut,
  output logic                       adOe,
  output logic [3:0]                 cbeOutN,
  output logic                       cbeOe,
  output logic                       parOut,
  output logic                       parOe,
  output logic                       nmiPulse,
  output logic                       mstDone,
  output logic [31:0]                mstRdData,
  output pscs_pkg::pscs_cfg_s        cfgAccess
);
  import pscs_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << PSCS_CNT_W)) begin : g_bad_cycles
    $error("RESET_CYCLES out of counter range");
  end

  localparam logic [PSCS_CNT_W-1:0] RST_LAST = PSCS_CNT_W'(RESET_CYCLES - 1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Even parity bit over the 36 bus bits
  function automatic logic parity36(input logic [31:0] ad, input logic [3:0] cbe);
    parity36 = ^{ad, cbe};
  endfunction : parity36

  // Config command check
  function automatic logic isCfgCmd(input logic [3:0] cmd);
    isCfgCmd = (cmd == PSCS_CMD_CFG_RD) || (cmd == PSCS_CMD_CFG_WR);
  endfunction : isCfgCmd

  pscs_state_s state_reg;
  pscs_state_s state_next;

  logic       addrPhase;
  logic [3:0] cbeOnBus;

  // Falling FRAME edge seen by the sampler marks an address phase
  assign addrPhase = state_reg.framePrev && !frameInN;
  // C/BE seen on the bus, own drive included
  assign cbeOnBus  = state_reg.cbeOe ? state_reg.cbeOut : cbeInN;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next           = state_reg;
    state_next.mstDone   = 1'b0;
    state_next.cfg.valid = 1'b0;
    state_next.nmi       = 1'b0;
    state_next.framePrev = frameInN;
    state_next.serrPrev  = serrInN;

    // Bus reset sequencing
    case (state_reg.rstSt)
      R_WAITPG: begin
        state_next.pciRstN = 1'b0;
        if (power_good_in) begin
          state_next.rstSt  = R_COUNT;
          state_next.rstCnt = PSCS_CNT_ZERO;
        end
      end
      R_COUNT: begin
        state_next.pciRstN = 1'b0;
        state_next.rstCnt  = state_reg.rstCnt + PSCS_CNT_ONE;
        if (!power_good_in) begin
          state_next.rstSt = R_WAITPG;
        end else if (state_reg.rstCnt == RST_LAST) begin
          state_next.rstSt   = R_RUN;
          state_next.pciRstN = 1'b1;
        end
      end
      R_RUN: begin
        if (!power_good_in) begin
          state_next.rstSt   = R_WAITPG;
          state_next.pciRstN = 1'b0;
        end else if (reset_control_register) begin
          state_next.rstSt   = R_COUNT;
          state_next.rstCnt  = PSCS_CNT_ZERO;
          state_next.pciRstN = 1'b0;
        end
      end
      default: begin
        state_next.rstSt   = R_WAITPG;
        state_next.pciRstN = 1'b0;
      end
    endcase

    // Hold request toward the arbiter
    state_next.holdReqOe = 1'b1;
    case (state_reg.holdSt)
      H_IDLE: begin
        state_next.holdReqN = 1'b1;
        if (mstReq.valid) begin
          state_next.holdSt   = H_REQ;
          state_next.holdReqN = 1'b0;
        end
      end
      H_REQ: begin
        if (!bus_hold_grant_n) begin
          state_next.holdSt = H_OWN;
        end
      end
      H_OWN: begin
        // Grant is assumed held until the request drops
        if (state_reg.mstSt == M_IDLE && passiveRelease) begin
          state_next.holdSt   = H_PREL;
          state_next.holdReqN = 1'b1;
        end else if (state_reg.mstSt == M_IDLE && !mstReq.valid) begin
          state_next.holdSt   = H_IDLE;
          state_next.holdReqN = 1'b1;
        end
      end
      H_PREL: begin
        state_next.holdSt   = H_REQ;
        state_next.holdReqN = 1'b0;
      end
      default: begin
        state_next.holdSt   = H_IDLE;
        state_next.holdReqN = 1'b1;
      end
    endcase

    // Initiator transfer, single data phase
    case (state_reg.mstSt)
      M_IDLE: begin
        if (state_reg.holdSt == H_OWN && mstReq.valid && !passiveRelease &&
            state_reg.tgtSt == T_IDLE) begin
          state_next.mstSt    = M_ADDR;
          state_next.mstWrite = mstReq.write;
          state_next.frameN   = 1'b0;
          state_next.frameOe  = 1'b1;
          state_next.adOut    = {mstReq.addr[31:2], PSCS_ADDR_LOW};
          state_next.adOe     = 1'b1;
          state_next.cbeOut   = mstReq.cmd;
          state_next.cbeOe    = 1'b1;
        end
      end
      M_ADDR: begin
        state_next.mstSt  = M_DATA;
        state_next.frameN = 1'b1;
        state_next.cbeOut = mstReq.be;
        state_next.adOut  = mstReq.data;
        state_next.adOe   = state_reg.mstWrite;
        state_next.irdyOe = 1'b1;
        state_next.irdyN  = !mstReq.ready;
      end
      M_DATA: begin
        if (!state_reg.irdyN && !trdyInN) begin
          state_next.mstSt     = M_TURN;
          state_next.mstDone   = 1'b1;
          state_next.mstRdData = adIn;
          state_next.irdyN     = 1'b1;
          state_next.frameOe   = 1'b0;
          state_next.adOe      = 1'b0;
          state_next.cbeOe     = 1'b0;
        end else begin
          state_next.irdyN = state_reg.irdyN && !mstReq.ready;
        end
      end
      M_TURN: begin
        state_next.mstSt  = M_IDLE;
        state_next.irdyOe = 1'b0;
      end
      default: begin
        state_next.mstSt  = M_IDLE;
        state_next.irdyOe = 1'b0;
      end
    endcase

    // Target side for config cycles
    case (state_reg.tgtSt)
      T_IDLE: begin
        if (addrPhase && idsel && isCfgCmd(cbeInN) &&
            state_reg.mstSt == M_IDLE) begin
          state_next.tgtSt    = T_DATA;
          state_next.tgtWrite = (cbeInN == PSCS_CMD_CFG_WR);
          state_next.tgtAddr  = adIn;
          state_next.devselN  = 1'b0;
          state_next.devselOe = 1'b1;
          state_next.trdyN    = 1'b0;
          state_next.trdyOe   = 1'b1;
          state_next.adOut    = cfgRdData;
          state_next.adOe     = (cbeInN == PSCS_CMD_CFG_RD);
        end
      end
      T_DATA: begin
        if (!irdyInN && !state_reg.trdyN) begin
          state_next.cfg.valid = 1'b1;
          state_next.cfg.write = state_reg.tgtWrite;
          state_next.cfg.addr  = state_reg.tgtAddr;
          state_next.cfg.data  = adIn;
          state_next.cfg.be    = cbeInN;
          state_next.tgtAddr   = state_reg.tgtAddr + PSCS_WORD_STEP;
          state_next.adOut     = cfgRdData;
          if (frameInN) begin
            state_next.tgtSt   = T_TURN;
            state_next.devselN = 1'b1;
            state_next.trdyN   = 1'b1;
            state_next.adOe    = 1'b0;
          end
        end
      end
      T_TURN: begin
        state_next.tgtSt    = T_IDLE;
        state_next.devselOe = 1'b0;
        state_next.trdyOe   = 1'b0;
      end
      default: begin
        state_next.tgtSt    = T_IDLE;
        state_next.devselOe = 1'b0;
        state_next.trdyOe   = 1'b0;
      end
    endcase

    // Parity trails the AD drive by one clock
    state_next.parOe = state_reg.adOe;
    state_next.par   = parity36(state_reg.adOut, cbeOnBus);

    // System error response
    if (serrNmiEnable && state_reg.serrPrev && !serrInN) begin
      state_next.nmi = 1'b1;
    end

    // Power-on suspend floats the bus, holds reset and hold high
    if (posState) begin
      state_next           = PSCS_STATE_RST;
      state_next.rstSt     = R_RUN;
      state_next.pciRstN   = 1'b1;
      state_next.holdReqN  = 1'b1;
      state_next.holdReqOe = 1'b1;
      state_next.framePrev = frameInN;
      state_next.serrPrev  = serrInN;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= PSCS_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from the state register
  // ---------------------------------------------------------------
  // Reset pin timed by the counter, not by bus edges
  assign pci_bus_reset_out_n = state_reg.pciRstN;
  assign bus_hold_request_n  = state_reg.holdReqN;
  assign bus_hold_request_oe = state_reg.holdReqOe;
  assign frameOutN           = state_reg.frameN;
  assign frameOe             = state_reg.frameOe;
  assign irdyOutN            = state_reg.irdyN;
  assign irdyOe              = state_reg.irdyOe;
  assign devselOutN          = state_reg.devselN;
  assign devselOe            = state_reg.devselOe;
  assign trdyOutN            = state_reg.trdyN;
  assign trdyOe              = state_reg.trdyOe;
  assign adOut               = state_reg.adOut;
  assign adOe                = state_reg.adOe;
  assign cbeOutN             = state_reg.cbeOut;
  assign cbeOe               = state_reg.cbeOe;
  assign parOut              = state_reg.par;
  assign parOe               = state_reg.parOe;
  assign nmiPulse            = state_reg.nmi;
  assign mstDone             = state_reg.mstDone;
  assign mstRdData           = state_reg.mstRdData;
  assign cfgAccess           = state_reg.cfg;

endmodule : pscs_pci_ctl

/* File: pscs_pci_ctl_chk.sv */
// Checker for the PCI-side control block, bound to its top module.
// Assumes the top module's port names and one clock domain.
`timescale 1ns/1ns

module pscs_pci_ctl_chk
  import pscs_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = PSCS_RST_CYCLES
) (
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          power_good_in,
  input wire logic          posState,
  input wire logic          reset_control_register,
  input wire logic          serrNmiEnable,
  input wire pscs_mst_req_s mstReq,
  input wire logic          idsel,
  input wire logic          frameInN,
  input wire logic          trdyInN,
  input wire logic          serrInN,
  input wire logic [31:0]   adIn,
  input wire logic [3:0]    cbeInN,
  input wire logic          pci_bus_reset_out_n,
  input wire logic          bus_hold_request_n,
  input wire logic          bus_hold_request_oe,
  input wire logic          frameOe,
  input wire logic          irdyOutN,
  input wire logic          irdyOe,
  input wire logic          devselOutN,
  input wire logic          devselOe,
  input wire logic          adOe,
  input wire logic          parOut,
  input wire logic          parOe,
  input wire logic          nmiPulse,
  input wire logic          mstDone
);
  import pscs_pkg::*;
  // ---------------------------------------------------------------
  // Helper: cycles of bus reset held low with power good
  // ---------------------------------------------------------------
  logic [PSCS_CNT_W-1:0] lowCnt;
  always_ff @(posedge clk) begin
    if (!rst_n || pci_bus_reset_out_n || !power_good_in) lowCnt <= PSCS_CNT_ZERO;
    else lowCnt <= lowCnt + PSCS_CNT_ONE;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_devsel_claim: assert property ($fell(frameInN) && idsel && !frameOe &&
    (cbeInN == PSCS_CMD_CFG_RD || cbeInN == PSCS_CMD_CFG_WR) |=> !devselOutN && devselOe)
    else $error("config access not claimed");
  a_devsel_idle: assert property ($fell(frameInN) && !idsel |=> !devselOe)
    else $error("claim without chip select");
  a_par_follow: assert property (parOe == $past(adOe))
    else $error("parity drive not one clock behind data");
  a_par_even: assert property (parOe |-> parOut == ^{$past(adIn), $past(cbeInN)})
    else $error("parity not even");
  a_irdy_ready: assert property (irdyOe && !irdyOutN |-> $past(mstReq.ready))
    else $error("ready asserted without data");
  a_irdy_start: assert property ($rose(irdyOe) |-> $past(frameOe))
    else $error("ready driven outside own cycle");
  a_phase_done: assert property (irdyOe && !irdyOutN && !trdyInN |=> mstDone)
    else $error("completed phase not reported");
  a_reset_long: assert property ($rose(pci_bus_reset_out_n) && !posState |->
    lowCnt >= RESET_CYCLES) else $error("bus reset too short");
  a_hard_reset: assert property (reset_control_register && power_good_in && !posState &&
    pci_bus_reset_out_n |=> !pci_bus_reset_out_n) else $error("hard reset not started");
  a_prel_pulse: assert property ($rose(bus_hold_request_n) && bus_hold_request_oe &&
    mstReq.valid |=> !bus_hold_request_n) else $error("passive release not one clock");
  a_serr_nmi: assert property ($fell(serrInN) |=> nmiPulse == $past(serrNmiEnable))
    else $error("system error response wrong");
endmodule : pscs_pci_ctl_chk

/* File: pscs_pci_ctl_tb.sv */
// Testbench: reset timing, master cycles, config claims, errors, suspend.
// Assumes pscs_pkg, pscs_pci_ctl, its checker and the agent model.
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
`define WAITT(c) begin for (w = 0; w < 200 && !(c); w++) @(posedge clk); \
  if (w == 200) begin errorCnt++; printVerdict(); end end

module pscs_pci_ctl_tb;
  import pscs_pkg::*;
  localparam int unsigned RCYC = 8;
  logic clk = 0, rst_n = 0, power_good_in = 0, posState = 0, reset_control_register = 0;
  logic serrNmiEnable = 0, passiveRelease = 0, idsel = 0, serrInN = 1, tbFrameN = 1, tbIrdyN = 1;
  logic tbAdOe = 0, frameInN, irdyInN, trdyInN, holdLineN, bus_hold_grant_n, agTrdyN, agTrdyOe, agAdOe;
  logic [31:0] cfgRdData = 0, tbAd = 0, readWord = 0, adIn, agAd, adLast = 0, adOut, mstRdData;
  logic [3:0]  tbCbeN = 4'hf, cbeInN, cbeOutN, grantDelay = 0, trdyDelay = 0;
  logic pci_bus_reset_out_n, bus_hold_request_n, bus_hold_request_oe, frameOutN, frameOe, irdyOutN;
  logic irdyOe, devselOutN, devselOe, trdyOutN, trdyOe, adOe, cbeOe, parOut, parOe, nmiPulse, mstDone;
  pscs_mst_req_s mstReq = '0;
  pscs_cfg_s     cfgAccess;
  int w, compares = 0, errorCnt = 0;
  logic [3:0] cmdTab [5] = '{4'ha, 4'hb, 4'ha, 4'h6, 4'hb};
  logic       selTab [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

  pscs_pci_ctl #(.RESET_CYCLES(RCYC)) pscs_pci_ctl_i (.*);
  pscs_pci_agent pscs_pci_agent_i (.*);

  // ---------------------------------------------------------------
  // Clock and bus resolution; released AD shows inverse of last value
  // ---------------------------------------------------------------
  always #2 clk = ~clk;
  assign frameInN  = frameOe ? frameOutN : tbFrameN;
  assign irdyInN   = irdyOe ? irdyOutN : tbIrdyN;
  assign trdyInN   = trdyOe ? trdyOutN : (agTrdyOe ? agTrdyN : 1'b1);
  assign cbeInN    = cbeOe ? cbeOutN : tbCbeN;
  assign adIn      = adOe ? adOut : agAdOe ? agAd : tbAdOe ? tbAd : ~adLast;
  assign holdLineN = bus_hold_request_oe ? bus_hold_request_n : 1'b1;
  always @(posedge clk) adLast <= adIn;

  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  function automatic logic cfgClaims(input logic [3:0] c, input logic s);
    return s && (c == PSCS_CMD_CFG_RD || c == PSCS_CMD_CFG_WR);
  endfunction : cfgClaims

  task automatic printVerdict();
    $display("compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : printVerdict

  task automatic measureReset();
    int n;
    @(posedge clk);
    `WAITT(!pci_bus_reset_out_n)
    for (n = 0; n < 1000 && !pci_bus_reset_out_n; n++) @(posedge clk);
    `CHK("bus reset length", 2'b11, {n >= RCYC, pci_bus_reset_out_n})
  endtask : measureReset

  task automatic mstXfer(input logic wr, input logic late, input logic first, input logic prel);
    logic [31:0] a, d, rd;
    logic [3:0]  cmd, be;
    a = {30'($urandom), PSCS_ADDR_LOW};
    d = $urandom;
    rd = $urandom;
    be = 4'($urandom);
    cmd = wr ? 4'h7 : 4'h6;
    readWord <= rd;
    grantDelay <= 4'($urandom % 4);
    trdyDelay <= 4'($urandom % 4);
    passiveRelease <= prel;
    mstReq <= '{valid: 1'b1, write: wr, addr: a, cmd: cmd, be: be, data: d, ready: !late};
    if (prel) begin
      `WAITT(bus_hold_request_n)
      passiveRelease <= 1'b0;
    end
    if (first) begin
      repeat (2) @(posedge clk);
      `CHK("hold request", 1'b0, bus_hold_request_n)
    end
    `WAITT(frameOe && !frameOutN)
    `CHK("address phase", {a, cmd}, {adOut, cbeOutN})
    @(posedge clk);
    `CHK("byte enables", be, cbeOutN)
    if (wr) `CHK("write data", d, adOut)
    if (late) begin
      repeat (3) @(posedge clk);
      `CHK("ready held back", 1'b1, irdyOutN)
      mstReq.ready <= 1'b1;
    end
    `WAITT(mstDone)
    if (!wr) `CHK("read data", rd, mstRdData)
  endtask : mstXfer

  task automatic cfgCycle(input logic [3:0] cmd, input logic sel);
    logic [31:0] a, d, rdExp;
    logic        claim;
    logic [3:0]  be;
    a = {30'($urandom), PSCS_ADDR_LOW};
    d = $urandom;
    rdExp = $urandom;
    be = 4'($urandom);
    claim = cfgClaims(cmd, sel);
    cfgRdData <= rdExp;
    {tbFrameN, tbAdOe, tbAd, tbCbeN, idsel} <= {2'b01, a, cmd, sel};
    @(posedge clk);
    {tbFrameN, tbIrdyN, tbCbeN, idsel, tbAd, tbAdOe} <= {2'b10, be, 1'b0, d, cmd[0]};
    @(posedge clk);
    `CHK("config claim", (claim ? 4'h5 : 4'ha), {devselOutN, devselOe, trdyOutN, trdyOe})
    if (claim && !cmd[0]) `CHK("config read data", rdExp, adIn)
    tbIrdyN <= 1'b1;
    tbAdOe <= 1'b0;
    @(posedge clk);
    if (claim) `CHK("config access", {1'b1, cmd[0], a}, {cfgAccess.valid, cfgAccess.write, cfgAccess.addr})
    else `CHK("no config access", 1'b0, cfgAccess.valid)
    if (claim && cmd[0]) `CHK("config write data", d, cfgAccess.data)
    if (claim) `CHK("config byte enables", be, cfgAccess.be)
    @(posedge clk);
  endtask : cfgCycle

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(6660));
    repeat (10) @(posedge clk);
    `CHK("pins in reset", 3'b000, {pci_bus_reset_out_n, bus_hold_request_oe, irdyOe})
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("hold after reset", 2'b11, {bus_hold_request_oe, bus_hold_request_n})
    power_good_in <= 1'b1;
    measureReset();
    reset_control_register <= 1'b1;
    @(posedge clk);
    reset_control_register <= 1'b0;
    measureReset();
    for (int i = 0; i < 6; i++) begin
      mstXfer(i < 2 ? 1'(i) : 1'($urandom), i == 1, i == 0 || i == 4, i == 3);
      if (i == 3 || i == 5) begin
        mstReq.valid <= 1'b0;
        `WAITT(bus_hold_request_n)
      end
    end
    for (int k = 0; k < 5; k++) cfgCycle(cmdTab[k], selTab[k]);
    for (int k = 0; k < 2; k++) begin
      serrNmiEnable <= 1'(k);
      serrInN <= 1'b0;
      @(posedge clk);
      serrInN <= 1'b1;
      @(posedge clk);
      `CHK("nmi pulse", 1'(k), nmiPulse)
    end
    posState <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("suspend pins", 3'b110, {pci_bus_reset_out_n, bus_hold_request_n, irdyOe})
    printVerdict();
  end
endmodule : pscs_pci_ctl_tb

bind pscs_pci_ctl pscs_pci_ctl_chk #(.RESET_CYCLES(RESET_CYCLES)) pscs_pci_ctl_chk_i (.*);

/* File: pscs_pkg.sv */
// Package for the PCI-side control block of the bridge.
// Assumes one 250 MHz clock that also serves as the PCI bus clock.
package pscs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned PSCS_CLK_PERIOD_PS = 4000;        // 250 MHz
  localparam int unsigned PSCS_RST_TIME_US   = 1000;        // 1 ms least
  localparam int unsigned PSCS_RST_CYCLES    =
    (PSCS_RST_TIME_US * 1000000 + PSCS_CLK_PERIOD_PS - 1) / PSCS_CLK_PERIOD_PS;
  localparam int unsigned PSCS_CNT_W         = 24;

  // ---------------------------------------------------------------
  // Bus commands and field sizes
  // ---------------------------------------------------------------
  localparam logic [3:0] PSCS_CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] PSCS_CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] PSCS_BE_NONE     = 4'hf;
  localparam logic [1:0] PSCS_ADDR_LOW    = 2'h0;
  localparam logic [31:0] PSCS_WORD_STEP  = 32'h4;
  localparam logic [31:0] PSCS_WORD_ZERO  = 32'h0;
  localparam logic [PSCS_CNT_W-1:0] PSCS_CNT_ZERO = 24'h0;
  localparam logic [PSCS_CNT_W-1:0] PSCS_CNT_ONE  = 24'h1;

  // ---------------------------------------------------------------
  // State encodings, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {R_WAITPG = 3'h1, R_COUNT = 3'h2, R_RUN = 3'h4} pscs_rst_e;
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_REQ = 4'h2, H_OWN = 4'h4, H_PREL = 4'h8} pscs_hold_e;
  typedef enum logic [3:0] {M_IDLE = 4'h1, M_ADDR = 4'h2, M_DATA = 4'h4, M_TURN = 4'h8} pscs_mst_e;
  typedef enum logic [2:0] {T_IDLE = 3'h1, T_DATA = 3'h2, T_TURN = 3'h4} pscs_tgt_e;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;   // Request held until done
    logic        write;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  be;      // Active-low byte enables
    logic [31:0] data;
    logic        ready;   // Write data valid or read latch ready
  } pscs_mst_req_s;

  typedef struct packed {
    logic        valid;   // One-cycle strobe
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
  } pscs_cfg_s;

  typedef struct packed {
    pscs_rst_e             rstSt;
    logic [PSCS_CNT_W-1:0] rstCnt;
    logic                  pciRstN;
    pscs_hold_e            holdSt;
    logic                  holdReqN;
    logic                  holdReqOe;
    pscs_mst_e             mstSt;
    logic                  mstWrite;
    logic                  frameN;
    logic                  frameOe;
    logic                  irdyN;
    logic                  irdyOe;
    logic [31:0]           adOut;
    logic                  adOe;
    logic [3:0]            cbeOut;
    logic                  cbeOe;
    logic                  mstDone;
    logic [31:0]           mstRdData;
    pscs_tgt_e             tgtSt;
    logic                  tgtWrite;
    logic [31:0]           tgtAddr;
    logic                  devselN;
    logic                  devselOe;
    logic                  trdyN;
    logic                  trdyOe;
    pscs_cfg_s             cfg;
    logic                  par;
    logic                  parOe;
    logic                  framePrev;
    logic                  serrPrev;
    logic                  nmi;
  } pscs_state_s;

  localparam pscs_state_s PSCS_STATE_RST = '{
    rstSt: R_WAITPG, rstCnt: PSCS_CNT_ZERO, pciRstN: 1'b0,
    holdSt: H_IDLE, holdReqN: 1'b1, holdReqOe: 1'b0,
    mstSt: M_IDLE, mstWrite: 1'b0, frameN: 1'b1, frameOe: 1'b0,
    irdyN: 1'b1, irdyOe: 1'b0, adOut: PSCS_WORD_ZERO, adOe: 1'b0,
    cbeOut: PSCS_BE_NONE, cbeOe: 1'b0, mstDone: 1'b0, mstRdData: PSCS_WORD_ZERO,
    tgtSt: T_IDLE, tgtWrite: 1'b0, tgtAddr: PSCS_WORD_ZERO,
    devselN: 1'b1, devselOe: 1'b0, trdyN: 1'b1, trdyOe: 1'b0,
    cfg: '0, par: 1'b0, parOe: 1'b0, framePrev: 1'b1, serrPrev: 1'b1, nmi: 1'b0};

endpackage : pscs_pkg
